// ==== hdl/fspc_params.svh ====
// constants of the flash self-programming controller: offsets, fields, codes, timing
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus
// Operation
// RULE_01 - array is rows of 32 words; erase 1, 2 or 4 rows, program one row
// RULE_02 - erase and write blocks are aligned to their own size from address zero
// RULE_03 - table writes only load holding latches; array changes only on an operation
// RULE_04 - row program works with any latch count; 32 loads fill a whole row
// RULE_05 - latches load in any order; a later write replaces earlier contents
// RULE_06 - a latch load is a short buffer write; every row needs its own cycle
// RULE_07 - program address is table page concatenated with the 16-bit effective address
// RULE_08 - low table read and write reach bits 15 to 0, word or byte
// RULE_09 - high table read and write reach bits 23 to 16, word or byte
// RULE_10 - software writes 55h then AAh to the key register before starting
// RULE_11 - processor stalls while a program or erase operation runs
// RULE_12 - start bit 15 is set only by software, cleared by hardware at the end
// RULE_13 - write enable bit 14 allows operations when 1, inhibits them when 0
// RULE_14 - sequence error bit 13 sets on a bad start; reads 0 after normal end
// RULE_15 - erase select bit 6 chooses erase variant of the operation code
// RULE_16 - erase codes 011000/011001/011010 erase 1/2/4 rows at the table pointer
// RULE_17 - erase codes for boot, all, configuration, data eeprom and general blocks
// RULE_18 - boot and whole-memory erase act only in serial programming mode
// RULE_19 - with erase clear, code 0001xx programs one row from the latches
// RULE_20 - any other operation code does nothing when started
// RULE_21 - bit 12 only for data eeprom; bits 11 to 7 read as zero
// RULE_22 - start without fresh unlock or with write enable clear sets sequence error
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH

// register byte offsets
`define FSPC_OFS_CTRL 8'h00
`define FSPC_OFS_KEY 8'h04
`define FSPC_OFS_PAGE 8'h08
`define FSPC_OFS_EFFECTIVE_ADDRESS 8'h0C
`define FSPC_OFS_TLOW 8'h10
`define FSPC_OFS_THIGH 8'h14

// control register fields
`define FSPC_BIT_WR 15
`define FSPC_BIT_OP_WRITE_ENABLE 14
`define FSPC_BIT_SEQUENCE_ERROR_FLAG 13
`define FSPC_BIT_PROGRAM_ONLY_ENABLE 12
`define FSPC_BIT_ERASE 6
`define FSPC_CTRL_RESET 16'h0000

// unlock keys
`define FSPC_KEY1 8'h55
`define FSPC_KEY2 8'hAA

// operation codes
`define FSPC_OP_ROW1 6'h18
`define FSPC_OP_ROW2 6'h19
`define FSPC_OP_ROW4 6'h1A
`define FSPC_OPG_BOOT 4'hA
`define FSPC_OPG_ALL 4'h9
`define FSPC_OPG_CFG 4'h5
`define FSPC_OPG_EE 4'h4
`define FSPC_OPG_GEN 4'h3
`define FSPC_OPG_PROG 4'h1

// geometry
`define FSPC_ROW_WORDS 32
`define FSPC_ERASED 24'hFFFFFF

// self-timed operation length
`define FSPC_CLK_MHZ 100
`define FSPC_OP_TIME_NS 2000
`define FSPC_OP_CYC ((`FSPC_OP_TIME_NS * `FSPC_CLK_MHZ + 999) / 1000)

`endif

// ==== hdl/fspc_pkg.sv ====
// types of the flash self-programming controller
// assumes fspc_params.svh for all numeric constants
package fspc_pkg;

  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fspc_key_t;

  typedef enum logic [1:0] {SQ_IDLE, SQ_WRITE, SQ_WAIT, SQ_DONE} fspc_seq_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic wr;
    logic op_write_enable;
    logic sequence_error_flag;
    logic program_only_enable;
    logic erase;
    logic [5:0] op;
    fspc_key_t key;
    logic [7:0] page;
    logic [15:0] effective_address;
    logic [31:0][23:0] latch;
    fspc_seq_t sq;
    logic prog;
    logic [23:0] addr;
    logic [23:0] cnt;
    logic [15:0] wait_cnt;
    logic fl_we;
    logic [23:0] fl_addr;
    logic [23:0] fl_wdata;
    logic serial_meta;
    logic serial;
  } fspc_state_t;

endpackage : fspc_pkg

// ==== hdl/fspc_ctrl.sv ====
// flash self-programming controller: table latches, unlock, self-timed sequencer
// assumes a flash array with asynchronous read and one-word synchronous write
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`include "fspc_params.svh"

module fspc_ctrl import fspc_pkg::*; #(
  parameter int MEM_WORDS = 5632,
  parameter logic [23:0] CFG_BASE = 24'hF80000,
  parameter int CFG_WORDS = 8,
  parameter logic [23:0] EE_BASE = 24'h7FFE00,
  parameter int EE_WORDS = 256,
  parameter int OP_CYC = `FSPC_OP_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // processor stall
  output logic cpu_stall_o,
  // serial programming mode indication
  input wire logic serial_mode_i,
  // flash array port
  output logic fl_we_o,
  output logic [23:0] fl_addr_o,
  output logic [23:0] fl_wdata_o,
  input wire logic [23:0] fl_rdata_i
);

  fspc_state_t s_q;
  fspc_state_t s_d;
  logic take;
  logic wr_set;
  logic start_ok;
  logic [23:0] tbl_addr;
  logic [4:0] lidx;
  logic [5:0] opc;
  logic ers;
  logic [23:0] base;
  logic [23:0] words;

  assign tbl_addr = {s_q.page, s_q.effective_address}; // see RULE_07
  assign lidx = s_q.effective_address[5:1]; // see RULE_05

  always_comb begin
    s_d = s_q;
    s_d.fl_we = 1'b0;
    // serial mode comes from the programming pins: two flops before use
    s_d.serial_meta = serial_mode_i;
    s_d.serial = s_q.serial_meta;
    wr_set = 1'b0;
    start_ok = 1'b0;
    opc = 6'h00;
    ers = 1'b0;
    base = 24'h000000;
    words = 24'h000000;
    // bus is held off while an operation runs
    take = wb_cyc_i & wb_stb_i & ~s_q.ack & (s_q.sq == SQ_IDLE); // see RULE_11
    s_d.ack = take;

    if (take && !wb_we_i) begin
      s_d.rdata = 32'h00000000;
      unique case (wb_adr_i)
        `FSPC_OFS_CTRL: begin
          // bits 11 to 7 stay zero
          s_d.rdata[15:0] = {s_q.wr, s_q.op_write_enable, s_q.sequence_error_flag,
                             s_q.program_only_enable, 5'h00,
                             s_q.erase, s_q.op}; // see RULE_21
        end
        `FSPC_OFS_PAGE: s_d.rdata[7:0] = s_q.page;
        `FSPC_OFS_EFFECTIVE_ADDRESS: s_d.rdata[15:0] = s_q.effective_address;
        `FSPC_OFS_TLOW: s_d.rdata[15:0] = fl_rdata_i[15:0]; // see RULE_08
        // phantom upper byte reads zero
        `FSPC_OFS_THIGH: s_d.rdata[7:0] = fl_rdata_i[23:16]; // see RULE_09
        default: s_d.rdata = 32'h00000000;
      endcase
    end

    if (take && wb_we_i) begin
      // any write other than the next key step breaks the unlock sequence
      s_d.key = KEY_IDLE; // see RULE_10
      unique case (wb_adr_i)
        `FSPC_OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            s_d.erase = wb_dat_i[`FSPC_BIT_ERASE];
            s_d.op = wb_dat_i[5:0];
          end
          if (wb_sel_i[1]) begin
            s_d.op_write_enable = wb_dat_i[`FSPC_BIT_OP_WRITE_ENABLE];
            s_d.sequence_error_flag = wb_dat_i[`FSPC_BIT_SEQUENCE_ERROR_FLAG];
            s_d.program_only_enable = wb_dat_i[`FSPC_BIT_PROGRAM_ONLY_ENABLE];
            // writing zero to the start bit has no effect
            wr_set = wb_dat_i[`FSPC_BIT_WR]; // see RULE_12
          end
        end
        `FSPC_OFS_KEY: begin
          if (wb_sel_i[0]) begin
            if (wb_dat_i[7:0] == `FSPC_KEY1) begin
              s_d.key = KEY_HALF;
            end else if (s_q.key == KEY_HALF && wb_dat_i[7:0] == `FSPC_KEY2) begin
              s_d.key = KEY_ARMED; // see RULE_10
            end
          end
        end
        `FSPC_OFS_PAGE: begin
          if (wb_sel_i[0]) begin
            s_d.page = wb_dat_i[7:0];
          end
        end
        `FSPC_OFS_EFFECTIVE_ADDRESS: begin
          if (wb_sel_i[0]) begin
            s_d.effective_address[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_d.effective_address[15:8] = wb_dat_i[15:8];
          end
        end
        `FSPC_OFS_TLOW: begin
          // latches only; configuration space refuses table writes
          if (!s_q.page[7]) begin // see RULE_03
            if (wb_sel_i[0]) begin
              s_d.latch[lidx][7:0] = wb_dat_i[7:0]; // see RULE_08
            end
            if (wb_sel_i[1]) begin
              s_d.latch[lidx][15:8] = wb_dat_i[15:8]; // see RULE_05
            end
          end
        end
        `FSPC_OFS_THIGH: begin
          if (!s_q.page[7] && wb_sel_i[0]) begin
            s_d.latch[lidx][23:16] = wb_dat_i[7:0]; // see RULE_09
          end
        end
        default: s_d.key = KEY_IDLE;
      endcase

      if (wr_set) begin
        // start needs a fresh unlock and the enable as written
        start_ok = (s_q.key == KEY_ARMED) && s_d.op_write_enable; // see RULE_13
        if (!start_ok) begin
          s_d.sequence_error_flag = 1'b1; // see RULE_22
        end
      end
    end

    if (start_ok) begin
      opc = s_d.op;
      ers = s_d.erase;
      if (ers) begin // see RULE_15
        if (opc == `FSPC_OP_ROW1) begin
          base = {tbl_addr[23:6], 6'h00}; // see RULE_02
          words = 24'(`FSPC_ROW_WORDS); // see RULE_16
        end else if (opc == `FSPC_OP_ROW2) begin
          base = {tbl_addr[23:7], 7'h00};
          words = 24'(2 * `FSPC_ROW_WORDS);
        end else if (opc == `FSPC_OP_ROW4) begin
          base = {tbl_addr[23:8], 8'h00};
          words = 24'(4 * `FSPC_ROW_WORDS); // see RULE_01
        end else if (opc[5:2] == `FSPC_OPG_GEN) begin
          base = 24'h000000; // see RULE_17
          words = 24'(MEM_WORDS);
        end else if (opc[5:2] == `FSPC_OPG_CFG) begin
          base = CFG_BASE;
          words = 24'(CFG_WORDS);
        end else if (opc[5:2] == `FSPC_OPG_EE) begin
          base = EE_BASE;
          words = 24'(EE_WORDS);
        end else if (opc[5:2] == `FSPC_OPG_ALL && s_q.serial) begin
          base = 24'h000000; // see RULE_18
          words = 24'(MEM_WORDS);
        end else if (opc[5:2] == `FSPC_OPG_BOOT && s_q.serial) begin
          base = 24'h000000;
          words = 24'(`FSPC_ROW_WORDS);
        end
      end else if (opc[5:2] == `FSPC_OPG_PROG) begin
        base = {tbl_addr[23:6], 6'h00}; // see RULE_19
        words = 24'(`FSPC_ROW_WORDS); // see RULE_06
      end
      // unlisted codes leave words at zero and go straight to done, which clears the start bit and the error flag
      s_d.wr = 1'b1; // see RULE_20
      // a no-op start must not wipe the loaded latches
      s_d.prog = ~ers && (words != 24'h000000);
      s_d.addr = base;
      s_d.cnt = words;
      s_d.sq = (words != 24'h000000) ? SQ_WRITE : SQ_DONE;
    end

    unique case (s_q.sq)
      SQ_IDLE: begin
      end
      SQ_WRITE: begin
        s_d.fl_we = 1'b1;
        s_d.fl_addr = s_q.addr;
        // unloaded latches hold the erased value
        s_d.fl_wdata = s_q.prog ? s_q.latch[s_q.addr[5:1]] : `FSPC_ERASED; // see RULE_04
        s_d.addr = s_q.addr + 24'h000002;
        s_d.cnt = s_q.cnt - 24'h000001;
        if (s_q.cnt == 24'h000001) begin
          s_d.sq = SQ_WAIT;
          s_d.wait_cnt = 16'(OP_CYC - 1);
        end
      end
      SQ_WAIT: begin
        s_d.wait_cnt = s_q.wait_cnt - 16'h0001;
        if (s_q.wait_cnt == 16'h0000) begin
          s_d.sq = SQ_DONE;
        end
      end
      SQ_DONE: begin
        s_d.wr = 1'b0; // see RULE_12
        s_d.sequence_error_flag = 1'b0; // see RULE_14
        if (s_q.prog) begin
          for (int i = 0; i < `FSPC_ROW_WORDS; i++) begin
            s_d.latch[i] = `FSPC_ERASED;
          end
        end
        s_d.sq = SQ_IDLE;
      end
    endcase

    // idle, finishing edge included: table pointer addresses the array for reads
    if (s_d.sq == SQ_IDLE) begin
      s_d.fl_addr = {s_d.page, s_d.effective_address};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h00000000;
      s_q.wr <= 1'b0;
      s_q.op_write_enable <= 1'b0;
      s_q.sequence_error_flag <= 1'b0;
      s_q.program_only_enable <= 1'b0;
      s_q.erase <= 1'b0;
      s_q.op <= 6'h00;
      s_q.key <= KEY_IDLE;
      s_q.page <= 8'h00;
      s_q.effective_address <= 16'h0000;
      s_q.latch <= {`FSPC_ROW_WORDS{`FSPC_ERASED}};
      s_q.sq <= SQ_IDLE;
      s_q.prog <= 1'b0;
      s_q.addr <= 24'h000000;
      s_q.cnt <= 24'h000000;
      s_q.wait_cnt <= 16'h0000;
      s_q.fl_we <= 1'b0;
      s_q.fl_addr <= 24'h000000;
      s_q.fl_wdata <= 24'h000000;
      s_q.serial_meta <= 1'b0;
      s_q.serial <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign cpu_stall_o = s_q.wr; // see RULE_11
  assign fl_we_o = s_q.fl_we;
  assign fl_addr_o = s_q.fl_addr;
  assign fl_wdata_o = s_q.fl_wdata;

endmodule : fspc_ctrl

// ==== verification/fspc_ctrl_checker.sv ====
// concurrent checks on the flash self-programming controller ports
// assumes one clock domain with synchronous active-high reset
`include "fspc_params.svh"

module fspc_ctrl_checker #(
  parameter int MEM_WORDS = 5632,
  parameter int OP_CYC = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic cpu_stall_o,
  input wire logic fl_we_o,
  input wire logic [23:0] fl_addr_o
);
  localparam int LIM = 4 * MEM_WORDS + OP_CYC + 300;
  logic [31:0] busy_q;
  logic req;
  assign req = wb_cyc_i && wb_stb_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || !cpu_stall_o) begin
      busy_q <= 32'h0;
    end else begin
      busy_q <= busy_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(req))
    else $error("ack without a request");
  a_idle_ack_next: assert property (req && !wb_ack_o && !cpu_stall_o |=> wb_ack_o)
    else $error("idle request not answered next cycle");
  a_busy_no_ack: assert property (cpu_stall_o && $past(cpu_stall_o) |-> !wb_ack_o)
    else $error("bus answered while processor stalled");
  a_array_in_op: assert property (fl_we_o |-> cpu_stall_o)
    else $error("array written outside an operation");
  a_start_cause: assert property ($rose(cpu_stall_o) |->
      $past(req && wb_we_i && wb_adr_i == `FSPC_OFS_CTRL && wb_dat_i[15]))
    else $error("operation started without a start write");
  a_op_bounded: assert property (busy_q <= LIM)
    else $error("operation never completes");
  a_block_aligned: assert property ($rose(fl_we_o) |-> fl_addr_o[5:0] == 6'h00)
    else $error("block not row aligned");
  a_word_step: assert property (fl_we_o && $past(fl_we_o) |->
      fl_addr_o == $past(fl_addr_o) + 24'h2)
    else $error("array address step not two");

  c_start: cover property ($rose(cpu_stall_o));
  c_array_write: cover property (fl_we_o);
  c_key_write: cover property (wb_ack_o && wb_adr_i == `FSPC_OFS_KEY);
endmodule : fspc_ctrl_checker

bind fspc_ctrl fspc_ctrl_checker #(.MEM_WORDS(MEM_WORDS), .OP_CYC(OP_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .cpu_stall_o(cpu_stall_o), .fl_we_o(fl_we_o), .fl_addr_o(fl_addr_o));

// ==== verification/flash_self_program_ctrl_test.sv ====
// self-checking bench for the flash self-programming controller
// assumes a 64-word array model behind the flash port, driven over wishbone
module flash_self_program_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, stall, fwe;
  logic [7:0] adr = 8'h00;
  logic ser = 1'b0;
  logic [31:0] dw = 32'h0, dr, q;
  logic [23:0] fa, fwd, frd;
  logic [23:0] mem [64];
  logic [31:0] bad [4] = '{32'h8058, 32'hC068, 32'hC07F, 32'hC058};
  logic [31:0] exp_rd [4] = '{32'h2058, 32'h4068, 32'h407F, 32'h6058};
  int error_cnt = 0;
  int check_count = 0;

  initial forever #5 clk_i = ~clk_i;
  assign frd = mem[fa[6:1]];
  always @(posedge clk_i) if (fwe) mem[fa[6:1]] <= fwd;

  fspc_ctrl #(.MEM_WORDS(64), .OP_CYC(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .cpu_stall_o(stall), .serial_mode_i(ser), .fl_we_o(fwe), .fl_addr_o(fa),
    .fl_wdata_o(fwd), .fl_rdata_i(frd));

  task results;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // one classic cycle, waits for ack under a bound
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 2000) begin
      error_cnt++;
      $display("Error at %0t: bus timeout", $time);
      results();
    end
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task unlock;
    wr(8'h04, 32'h55);
    wr(8'h04, 32'hAA);
  endtask : unlock

  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 24'h5A5A00 ^ 24'(i);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'hC018);
    rd(8'h00, 32'h6018);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h40);
    wr(8'h10, 32'h1111);
    wr(8'h14, 32'h22);
    wr(8'h10, 32'h3333);
    wr(8'h0C, 32'h7E);
    wr(8'h10, 32'hBEEF);
    wr(8'h14, 32'hAB);
    chk(32'(mem[32]), 32'h5A5A20);
    wr(8'h00, 32'h4004);
    unlock();
    wr(8'h00, 32'hC004);
    chk(32'(stall), 32'h1);
    rd(8'h00, 32'h4004);
    chk(32'(mem[32]), 32'h223333);
    chk(32'(mem[33]), 32'hFFFFFF);
    chk(32'(mem[63]), 32'hABBEEF);
    chk(32'(mem[31]), 32'h5A5A1F);
    wr(8'h0C, 32'h40);
    rd(8'h10, 32'h3333);
    rd(8'h14, 32'h22);
    unlock();
    // error flag written high with the start must read low after completion
    wr(8'h00, 32'hE058);
    rd(8'h00, 32'h4058);
    chk(32'(mem[32]), 32'hFFFFFF);
    chk(32'(mem[0]), 32'h5A5A00);
    // refused, boot without serial mode, nop code, broken key order
    for (int k = 0; k < 4; k++) begin
      mem[32] = 24'h0;
      wr(8'h04, 32'h55);
      if (k == 3) wr(8'h08, 32'h0);
      wr(8'h04, 32'hAA);
      wr(8'h00, bad[k]);
      rd(8'h00, exp_rd[k]);
      chk(32'(mem[32]), 32'h0);
      chk(32'(mem[0]), 32'h5A5A00);
    end
    // boot erase in serial mode clears the first row only
    ser <= 1'b1;
    unlock();
    wr(8'h00, 32'hC068);
    rd(8'h00, 32'h4068);
    chk(32'(mem[0]), 32'hFFFFFF);
    chk(32'(mem[32]), 32'h0);
    // general block erase
    unlock();
    wr(8'h00, 32'hC04C);
    rd(8'h00, 32'h404C);
    chk(32'(mem[32]), 32'hFFFFFF);
    // two-row erase aligned down from the top word of the pair
    mem[0] = 24'h0;
    mem[63] = 24'h0;
    wr(8'h0C, 32'h7E);
    unlock();
    wr(8'h00, 32'hC059);
    rd(8'h00, 32'h4059);
    chk(32'(mem[0]), 32'hFFFFFF);
    chk(32'(mem[63]), 32'hFFFFFF);
    results();
  end
endmodule : flash_self_program_ctrl_test
